/* hdl/ueif_top.sv */
// Endpoint short packet, interrupt enable and interrupt status logic with AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module ueif_top
#(
    parameter int NUM_EP = ueif_pkg::EP_COUNT
)
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                usb_bus_reset,
    input  wire logic [NUM_EP-1:0]   rx_filled,
    input  wire logic [NUM_EP-1:0]   tx_emptied,
    input  wire logic [NUM_EP-1:0]   out_accept,
    input  wire logic [NUM_EP-1:0]   out_short,
    input  wire logic [31:0]         awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [31:0]         araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    output logic                     irq
);

    localparam int IRQ_W = 2 * NUM_EP;

    // ************************************************************
    // Parameter check
    // ************************************************************
    generate
        if (NUM_EP < 1 || NUM_EP > ueif_pkg::EP_COUNT_MAX)
        begin : g_bad_num_ep
            $error("NUM_EP must lie between 1 and 16");
        end
    endgenerate

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                   aw_held;
    logic [31:0]            aw_addr_q;
    logic                   w_held;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   next_aw_held;
    logic [31:0]            next_aw_addr_q;
    logic                   next_w_held;
    logic [31:0]            next_w_data_q;
    logic [3:0]             next_w_strb_q;
    logic                   next_awready;
    logic                   next_wready;
    logic                   next_bvalid;
    logic [1:0]             next_bresp;
    logic                   wr_go;
    ueif_pkg::ueif_sel_e    wr_sel;

    logic                   next_arready;
    logic                   next_rvalid;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;

    logic [NUM_EP-1:0]      short_flags;
    logic [IRQ_W-1:0]       enable;
    logic [IRQ_W-1:0]       status;
    logic [NUM_EP-1:0]      next_short_flags;
    logic [IRQ_W-1:0]       next_enable;
    logic [IRQ_W-1:0]       next_status;
    logic                   next_irq;
    logic [IRQ_W-1:0]       ev_vec;
    logic [IRQ_W-1:0]       clr_vec;
    logic [IRQ_W-1:0]       frc_vec;
    logic [31:0]            wr_mask;

    // ************************************************************
    // Write channels
    // ************************************************************
    always_comb
    begin
        wr_sel         = ueif_pkg::ueif_decode(aw_addr_q);
        wr_go          = aw_held && w_held && !bvalid;
        next_aw_held   = aw_held;
        next_aw_addr_q = aw_addr_q;
        next_w_held    = w_held;
        next_w_data_q  = w_data_q;
        next_w_strb_q  = w_strb_q;
        next_bvalid    = bvalid;
        next_bresp     = bresp;
        // Address and data are taken independently, in either order
        if (awvalid && awready)
        begin
            next_aw_held   = 1'h1;
            next_aw_addr_q = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_held   = 1'h1;
            next_w_data_q = wdata;
            next_w_strb_q = wstrb;
        end
        if (bvalid && bready)
        begin
            next_bvalid = 1'h0;
        end
        if (wr_go)
        begin
            next_aw_held = 1'h0;
            next_w_held  = 1'h0;
            next_bvalid  = 1'h1;
            if (wr_sel == ueif_pkg::UEIF_SEL_NONE)
            begin
                next_bresp = ueif_pkg::RESP_DECERR;
            end
            else
            begin
                next_bresp = ueif_pkg::RESP_OKAY;
            end
        end
        // No new write is taken while a response is outstanding
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held   <= 1'h0;
            aw_addr_q <= ueif_pkg::ZERO_WORD;
            w_held    <= 1'h0;
            w_data_q  <= ueif_pkg::ZERO_WORD;
            w_strb_q  <= 4'h0;
            awready   <= 1'h0;
            wready    <= 1'h0;
            bvalid    <= 1'h0;
            bresp     <= ueif_pkg::RESP_OKAY;
        end
        else
        begin
            aw_held   <= next_aw_held;
            aw_addr_q <= next_aw_addr_q;
            w_held    <= next_w_held;
            w_data_q  <= next_w_data_q;
            w_strb_q  <= next_w_strb_q;
            awready   <= next_awready;
            wready    <= next_wready;
            bvalid    <= next_bvalid;
            bresp     <= next_bresp;
        end
    end

    // ************************************************************
    // Read channels
    // ************************************************************
    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (rvalid && rready)
        begin
            next_rvalid = 1'h0;
        end
        if (arvalid && arready)
        begin
            next_rvalid = 1'h1;
            next_rdata  = ueif_pkg::ZERO_WORD;
            next_rresp  = ueif_pkg::RESP_OKAY;
            case (ueif_pkg::ueif_decode(araddr))
                ueif_pkg::UEIF_SEL_SHORT:  next_rdata[NUM_EP-1:0] = short_flags; // [RL2] [RL4]
                ueif_pkg::UEIF_SEL_ENABLE: next_rdata[IRQ_W-1:0]  = enable;
                ueif_pkg::UEIF_SEL_STATUS: next_rdata[IRQ_W-1:0]  = status; // [RL8]
                ueif_pkg::UEIF_SEL_CLEAR:  next_rdata = ueif_pkg::ZERO_WORD; // [RL14]
                ueif_pkg::UEIF_SEL_FORCE:  next_rdata = ueif_pkg::ZERO_WORD; // [RL14]
                default:                   next_rresp = ueif_pkg::RESP_DECERR;
            endcase
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'h0;
            rvalid  <= 1'h0;
            rdata   <= ueif_pkg::ZERO_WORD;
            rresp   <= ueif_pkg::RESP_OKAY;
        end
        else
        begin
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // ************************************************************
    // Flags, enables, status and interrupt
    // ************************************************************
    always_comb
    begin
        wr_mask          = ueif_pkg::ueif_strb_mask(w_strb_q);
        ev_vec           = '0;
        clr_vec          = '0;
        frc_vec          = '0;
        next_short_flags = short_flags;
        next_enable      = enable;
        for (int n = 0; n < NUM_EP; n++)
        begin
            ev_vec[2*n]   = rx_filled[n]; // [RL9]
            ev_vec[2*n+1] = tx_emptied[n]; // [RL10]
            if (out_accept[n])
            begin
                next_short_flags[n] = out_short[n]; // [RL1] [RL18]
            end
        end
        if (wr_go && wr_sel == ueif_pkg::UEIF_SEL_ENABLE)
        begin
            next_enable = (enable & ~wr_mask[IRQ_W-1:0])
                        | (w_data_q[IRQ_W-1:0] & wr_mask[IRQ_W-1:0]); // [RL5] [RL6]
        end
        if (wr_go && wr_sel == ueif_pkg::UEIF_SEL_CLEAR)
        begin
            clr_vec = w_data_q[IRQ_W-1:0] & wr_mask[IRQ_W-1:0]; // [RL12] [RL15]
        end
        if (wr_go && wr_sel == ueif_pkg::UEIF_SEL_FORCE)
        begin
            frc_vec = w_data_q[IRQ_W-1:0] & wr_mask[IRQ_W-1:0]; // [RL13] [RL16]
        end
        // Events and forced bits win over a clear in the same cycle
        next_status = (status & ~clr_vec) | frc_vec | ev_vec; // [RL14]
        if (usb_bus_reset)
        begin
            next_short_flags = '0; // [RL17]
            next_enable      = '0;
            next_status      = '0;
        end
        next_irq = |(next_status & next_enable); // [RL11]
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            short_flags <= '0; // [RL17]
            enable      <= '0;
            status      <= '0;
            irq         <= 1'h0;
        end
        else
        begin
            short_flags <= next_short_flags; // [RL3]
            enable      <= next_enable;
            status      <= next_status;
            irq         <= next_irq;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    short_update_a : assert property ( // [RL18]
        (|out_accept) && !usb_bus_reset
        |=> ((short_flags & $past(out_accept)) == ($past(out_short) & $past(out_accept))))
        else $error("Short flag not taken from accepted packet");

    short_ro_a : assert property ( // [RL3]
        !usb_bus_reset && out_accept == '0 |=> $stable(short_flags))
        else $error("Short flags changed without an accepted packet");

    event_set_a : assert property ( // [RL9]
        (|ev_vec) && !usb_bus_reset |=> ((status & $past(ev_vec)) == $past(ev_vec)))
        else $error("Buffer event did not set its status flag");

    force_set_a : assert property ( // [RL13]
        (|frc_vec) && !usb_bus_reset |=> ((status & $past(frc_vec)) == $past(frc_vec)))
        else $error("Set register write did not set status");

    clear_flag_a : assert property ( // [RL12]
        (|clr_vec) |=> ((status & $past(clr_vec) & ~$past(ev_vec | frc_vec)) == '0))
        else $error("Clear register write left a status flag set");

    irq_level_a : assert property ( // [RL11]
        irq == (|(status & enable)))
        else $error("Interrupt does not match enabled status");

    bus_reset_a : assert property ( // [RL17]
        usb_bus_reset |=> (short_flags == '0 && enable == '0 && status == '0 && !irq))
        else $error("Bus reset did not clear flags");

    enable_write_a : assert property ( // [RL5]
        wr_go && wr_sel == ueif_pkg::UEIF_SEL_ENABLE && w_strb_q == 4'hF && !usb_bus_reset
        |=> enable == $past(w_data_q[IRQ_W-1:0]))
        else $error("Enable register write not stored");

    wo_read_zero_a : assert property ( // [RL14]
        arvalid && arready
        && (ueif_pkg::ueif_decode(araddr) == ueif_pkg::UEIF_SEL_CLEAR
        || ueif_pkg::ueif_decode(araddr) == ueif_pkg::UEIF_SEL_FORCE)
        |=> rvalid && rdata == ueif_pkg::ZERO_WORD)
        else $error("Clear or set register read not zero");

    write_resp_a : assert property (
        wr_go |=> bvalid && !awready && !wready)
        else $error("Write response missing after accepted write");

    short_read_a : assert property ( // [RL2]
        arvalid && arready && ueif_pkg::ueif_decode(araddr) == ueif_pkg::UEIF_SEL_SHORT
        |=> rvalid && rdata[NUM_EP-1:0] == $past(short_flags))
        else $error("Short flag read does not match endpoint order");

    status_read_a : assert property ( // [RL8]
        arvalid && arready && ueif_pkg::ueif_decode(araddr) == ueif_pkg::UEIF_SEL_STATUS
        |=> rvalid && rdata[IRQ_W-1:0] == $past(status))
        else $error("Status read does not match flag layout");

    enable_read_a : assert property ( // [RL6]
        arvalid && arready && ueif_pkg::ueif_decode(araddr) == ueif_pkg::UEIF_SEL_ENABLE
        |=> rvalid && rdata[IRQ_W-1:0] == $past(enable))
        else $error("Enable read does not match stored enables");

    flag_keep_a : assert property ( // [RL14]
        !usb_bus_reset |=> ($past(status) & ~$past(clr_vec) & ~status) == '0)
        else $error("Status flag dropped without a clear");

    enable_hold_a : assert property ( // [RL5]
        !usb_bus_reset && !(wr_go && wr_sel == ueif_pkg::UEIF_SEL_ENABLE)
        |=> $stable(enable))
        else $error("Enable changed without an enable write");

    bad_addr_a : assert property (
        wr_go && wr_sel == ueif_pkg::UEIF_SEL_NONE |=> bresp == ueif_pkg::RESP_DECERR)
        else $error("Unmapped write not refused");

endmodule // ueif_top

/* pkg/ueif_pkg.sv */
// Constants, types and helpers shared by the endpoint interrupt flag block
// What this block does
// RL1: Each OUT endpoint keeps a flag telling whether its last packet was short.
// RL2: Short flag bit n belongs to endpoint n, bit 0 endpoint 0, bit 7 endpoint 7.
// RL3: The short packet register is read only; bus writes never change it.
// RL4: Upper short register bits above the eight flags carry no meaning for software.
// RL5: Enable bit 2n enables receive interrupts of OUT endpoint n.
// RL6: Enable bit 2n+1 enables transmit interrupts of IN endpoint n.
// RL7: Software writes zeros to enable bits 31:16 and ignores their read value.
// RL8: Status holds one flag per endpoint direction, receive even, transmit odd.
// RL9: Receive status flag sets when the endpoint OUT buffer fills with a packet.
// RL10: Transmit status flag sets when the endpoint IN buffer is emptied.
// RL11: Interrupt is requested while any status flag and its enable are both one.
// RL12: Writing one to a clear register bit clears the matching status flag.
// RL13: Writing one to a set register bit sets the matching status flag.
// RL14: Zero bits written to clear or set do nothing; both read as zero.
// RL15: Clear register layout mirrors status: bit 0 endpoint 0 receive, bit 1 transmit.
// RL16: The set register lets software force endpoint interrupt requests.
// RL17: Short flags, enables and status reset to zero on master and bus reset.
// RL18: Each accepted OUT packet overwrites that endpoint's short flag.
package ueif_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [31:0] SHORT_OFFSET  = 32'h8004_1024;
    localparam logic [31:0] ENABLE_OFFSET = 32'h8004_1090;
    localparam logic [31:0] STATUS_OFFSET = 32'h8004_1098;
    localparam logic [31:0] CLEAR_OFFSET  = 32'h8004_10A0;
    localparam logic [31:0] FORCE_OFFSET  = 32'h8004_10A4;

    // ************************************************************
    // Sizes, reset values and responses
    // ************************************************************
    localparam int          EP_COUNT      = 8;
    localparam int          EP_COUNT_MAX  = 16;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_DECERR   = 2'h3;

    typedef enum logic [2:0]
    {
        UEIF_SEL_NONE   = 3'b000,
        UEIF_SEL_SHORT  = 3'b001,
        UEIF_SEL_ENABLE = 3'b010,
        UEIF_SEL_STATUS = 3'b011,
        UEIF_SEL_CLEAR  = 3'b100,
        UEIF_SEL_FORCE  = 3'b101
    } ueif_sel_e;

    // Address decode shared by the read and write paths
    function automatic ueif_sel_e ueif_decode(input logic [31:0] addr);
        ueif_sel_e sel;
        case (addr)
            SHORT_OFFSET:  sel = UEIF_SEL_SHORT;
            ENABLE_OFFSET: sel = UEIF_SEL_ENABLE;
            STATUS_OFFSET: sel = UEIF_SEL_STATUS;
            CLEAR_OFFSET:  sel = UEIF_SEL_CLEAR;
            FORCE_OFFSET:  sel = UEIF_SEL_FORCE;
            default:       sel = UEIF_SEL_NONE;
        endcase
        return sel;
    endfunction

    // Byte strobes widened to a bit mask
    function automatic logic [31:0] ueif_strb_mask(input logic [3:0] strb);
        logic [31:0] mask;
        mask = ZERO_WORD;
        for (int b = 0; b < 4; b++)
        begin
            mask[b*8 +: 8] = {8{strb[b]}};
        end
        return mask;
    endfunction

endpackage

/* verif/ueif_host_model.sv */
// Far side model: endpoint buffer events and accepted OUT packets
`timescale 1ns/1ps
module ueif_host_model
(
    input  wire logic       aclk,
    output logic [7:0]      rx_filled,
    output logic [7:0]      tx_emptied,
    output logic [7:0]      out_accept,
    output logic [7:0]      out_short
);
    initial
    begin
        rx_filled  = 8'h00;
        tx_emptied = 8'h00;
        out_accept = 8'h00;
        out_short  = 8'h00;
    end

    // One cycle of events; the short qualifier shows junk outside its packet
    task automatic pulse(input logic [7:0] rx, input logic [7:0] tx,
                         input logic [7:0] acc, input logic [7:0] sh);
        rx_filled  <= rx;
        tx_emptied <= tx;
        out_accept <= acc;
        out_short  <= sh;
        @(posedge aclk);
        rx_filled  <= 8'h00;
        tx_emptied <= 8'h00;
        out_accept <= 8'h00;
        out_short  <= ~sh;
    endtask
endmodule // ueif_host_model

/* verif/usb_endpoint_irq_flags_test.sv */
// Self-checking bench of the endpoint interrupt flag block over AXI4-Lite
`timescale 1ns/1ps
module usb_endpoint_irq_flags_test;
    logic        aclk, aresetn, usb_bus_reset, irq;
    logic [7:0]  rx_filled, tx_emptied, out_accept, out_short;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] d;
    logic [31:0] e;
    int          num_errors;
    int          compares;

    ueif_top ueif_top_i
    (
        .aclk(aclk), .aresetn(aresetn), .usb_bus_reset(usb_bus_reset),
        .rx_filled(rx_filled), .tx_emptied(tx_emptied),
        .out_accept(out_accept), .out_short(out_short),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq)
    );

    ueif_host_model ueif_host_model_i
    (
        .aclk(aclk), .rx_filled(rx_filled), .tx_emptied(tx_emptied),
        .out_accept(out_accept), .out_short(out_short)
    );

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ************************************************************
    // Bus tasks and checking
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic step(inout int n);
        n++;
        if (n > 50)
        begin
            num_errors++;
            $display("MISMATCH at %0t: bus answer never came", $time);
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        n = 0;
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= v;
        wstrb   <= s;
        wvalid  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            step(n);
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask

    task automatic rd(input logic [31:0] a);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
            step(n);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        check(d, exp);
        check(32'(r), 32'(ueif_pkg::RESP_OKAY));
    endtask

    task automatic test_done(input string name);
        $display("Test %s finished", name);
    endtask

    // Puts every flag, enable and short bit to one before a reset
    task automatic load_all();
        wr(ueif_pkg::ENABLE_OFFSET, 32'h0000_FFFF, 4'hF);
        wr(ueif_pkg::FORCE_OFFSET, 32'h0000_FFFF, 4'hF);
        ueif_host_model_i.pulse(8'h00, 8'h00, 8'hFF, 8'hFF);
        check(32'(irq), 32'h0000_0001);
        rd_check(ueif_pkg::SHORT_OFFSET, 32'h0000_00FF);
    endtask

    task automatic check_zero();
        rd_check(ueif_pkg::SHORT_OFFSET, 32'h0000_0000);
        rd_check(ueif_pkg::ENABLE_OFFSET, 32'h0000_0000);
        rd_check(ueif_pkg::STATUS_OFFSET, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        num_errors    = 0;
        compares      = 0;
        aresetn       = 1'b0;
        usb_bus_reset = 1'b0;
        awaddr        = 32'h0000_0000;
        wdata         = 32'h0000_0000;
        araddr        = 32'h0000_0000;
        wstrb         = 4'h0;
        awvalid       = 1'b0;
        wvalid        = 1'b0;
        // Response channels stay ready, so each answer is taken as it shows
        bready        = 1'b1;
        arvalid       = 1'b0;
        rready        = 1'b1;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_check(ueif_pkg::SHORT_OFFSET, 32'h0000_0000);
        rd_check(ueif_pkg::ENABLE_OFFSET, 32'h0000_0000);
        rd_check(ueif_pkg::STATUS_OFFSET, 32'h0000_0000);
        rd_check(ueif_pkg::CLEAR_OFFSET, 32'h0000_0000);
        rd_check(ueif_pkg::FORCE_OFFSET, 32'h0000_0000);
        test_done("reset");
        // Upper enable bits always written as zero
        wr(ueif_pkg::ENABLE_OFFSET, 32'h0000_A5C3, 4'hF);
        rd_check(ueif_pkg::ENABLE_OFFSET, 32'h0000_A5C3);
        wr(ueif_pkg::ENABLE_OFFSET, 32'h0000_00FF, 4'h1);
        rd_check(ueif_pkg::ENABLE_OFFSET, 32'h0000_A5FF);
        wr(ueif_pkg::ENABLE_OFFSET, 32'h0000_0000, 4'hF);
        test_done("enable");
        for (int ep = 0; ep < 8; ep++)
        begin
            e = 32'h0000_0001 << (2 * ep);
            ueif_host_model_i.pulse(8'h01 << ep, 8'h00, 8'h00, 8'h00);
            rd_check(ueif_pkg::STATUS_OFFSET, e);
            check(32'(irq), 32'h0000_0000);
            wr(ueif_pkg::CLEAR_OFFSET, e, 4'hF);
            rd_check(ueif_pkg::STATUS_OFFSET, 32'h0000_0000);
            ueif_host_model_i.pulse(8'h00, 8'h01 << ep, 8'h00, 8'h00);
            rd_check(ueif_pkg::STATUS_OFFSET, e << 1);
            wr(ueif_pkg::CLEAR_OFFSET, e << 1, 4'hF);
            rd_check(ueif_pkg::STATUS_OFFSET, 32'h0000_0000);
        end
        test_done("events");
        wr(ueif_pkg::FORCE_OFFSET, 32'h0000_FFFF, 4'hF);
        rd_check(ueif_pkg::STATUS_OFFSET, 32'h0000_FFFF);
        check(32'(irq), 32'h0000_0000);
        wr(ueif_pkg::CLEAR_OFFSET, 32'h0000_0000, 4'hF);
        rd_check(ueif_pkg::STATUS_OFFSET, 32'h0000_FFFF);
        for (int b = 0; b < 16; b++)
        begin
            wr(ueif_pkg::ENABLE_OFFSET, 32'h0000_0001 << b, 4'hF);
            check(32'(irq), 32'h0000_0001);
            wr(ueif_pkg::CLEAR_OFFSET, 32'h0000_0001 << b, 4'hF);
            check(32'(irq), 32'h0000_0000);
            rd_check(ueif_pkg::STATUS_OFFSET, (32'h0000_FFFF << (b + 1)) & 32'h0000_FFFF);
        end
        test_done("interrupt");
        e = 32'h0000_0000;
        for (int ep = 0; ep < 8; ep++)
        begin
            e = e | (32'h0000_0001 << ep);
            ueif_host_model_i.pulse(8'h00, 8'h00, 8'h01 << ep, 8'h01 << ep);
            rd_check(ueif_pkg::SHORT_OFFSET, e);
        end
        ueif_host_model_i.pulse(8'h00, 8'h00, 8'hFF, 8'h0F);
        rd_check(ueif_pkg::SHORT_OFFSET, 32'h0000_000F);
        wr(ueif_pkg::SHORT_OFFSET, 32'h0000_00F0, 4'hF);
        check(32'(r), 32'(ueif_pkg::RESP_OKAY));
        rd_check(ueif_pkg::SHORT_OFFSET, 32'h0000_000F);
        test_done("short");
        wr(32'h8004_1028, 32'h0000_0001, 4'hF);
        check(32'(r), 32'(ueif_pkg::RESP_DECERR));
        rd(32'h8004_1028);
        check(32'(r), 32'(ueif_pkg::RESP_DECERR));
        check(d, 32'h0000_0000);
        test_done("unmapped");
        load_all();
        usb_bus_reset <= 1'b1;
        @(posedge aclk);
        usb_bus_reset <= 1'b0;
        check_zero();
        test_done("bus reset");
        load_all();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check_zero();
        test_done("master reset");
        report_and_stop();
    end
endmodule // usb_endpoint_irq_flags_test
